// >>> rtl/tbu_pkg.sv
// Shared constants, types and size arithmetic for the TX buffer command unpacker
`default_nettype none
package tbu_pkg;
	// Command A field positions
	localparam int unsigned A_FIRST_BIT = 13;
	localparam int unsigned A_LAST_BIT = 12;
	localparam int unsigned A_SIZE_MSB = 10;
	localparam int unsigned A_OFF_LSB = 16;
	localparam int unsigned A_OFF_MSB = 20;
	localparam int unsigned A_ALIGN_LSB = 24;
	localparam int unsigned A_ALIGN_MSB = 25;
	// Command B field positions
	localparam int unsigned B_TAG_LSB = 16;
	localparam int unsigned B_TAG_MSB = 31;
	localparam int unsigned B_CRC_DIS_BIT = 13;
	localparam int unsigned B_PAD_DIS_BIT = 12;
	localparam int unsigned B_LEN_MSB = 10;
	// Bits that may be nonzero; all others are reserved
	localparam logic [31:0] CMD_A_MASK = 32'h831f_37ff;
	localparam logic [31:0] CMD_B_MASK = 32'hffff_37ff;
	// End alignment codes
	localparam logic [1:0] ALIGN_4 = 2'h0;
	localparam logic [1:0] ALIGN_16 = 2'h1;
	localparam logic [1:0] ALIGN_32 = 2'h2;
	// Host-side fragmentation limits
	localparam logic [11:0] MIN_MID_BYTES = 12'h004;
	localparam logic [7:0] MAX_FRAGS = 8'h56;
	localparam logic [11:0] SF_LIMIT_BYTES = 12'h7f4;

	typedef enum logic [2:0] {
		DS_CMD_A = 3'b001,
		DS_CMD_B = 3'b010,
		DS_BODY = 3'b100
	} tbu_dev_state_t;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_CMD_B = 3'b010,
		HS_DATA = 3'b100
	} tbu_host_state_t;

	// DWORDs following the two command words, offset and padding included
	function automatic logic [11:0] tbu_total_dw(input logic [4:0] off, input logic [10:0] size,
		input logic [1:0] align);
		logic [11:0] s;
		s = {7'h00, off} + {1'b0, size};
		case (align)
			ALIGN_16: return ((s + 12'h00f) >> 4) << 2;
			ALIGN_32: return ((s + 12'h01f) >> 5) << 3;
			// Reserved code handled as 4-byte alignment
			default: return (s + 12'h003) >> 2;
		endcase
	endfunction : tbu_total_dw

	// Index one past the last DWORD holding payload
	function automatic logic [11:0] tbu_data_end_dw(input logic [4:0] off, input logic [10:0] size);
		logic [11:0] s;
		s = {7'h00, off} + {1'b0, size};
		return (s + 12'h003) >> 2;
	endfunction : tbu_data_end_dw

	// Lanes of DWORD idx that carry payload bytes
	function automatic logic [3:0] tbu_byte_en(input logic [11:0] idx, input logic [4:0] off,
		input logic [10:0] size);
		logic [3:0] be;
		logic [11:0] pos;
		logic [11:0] lim;
		be = 4'h0;
		lim = {7'h00, off} + {1'b0, size};
		for (int k = 0; k < 4; k++)
		begin
			pos = {idx[9:0], 2'(k)};
			be[k] = (pos >= {7'h00, off}) && (pos < lim);
		end
		return be;
	endfunction : tbu_byte_en
endpackage : tbu_pkg
`default_nettype wire

// >>> rtl/tbu_if.sv
// Link between the host writer and the TX buffer command unpacker
`default_nettype none
interface tbu_if;
	logic wr_valid;
	logic [31:0] wr_data;
	logic err_clear;
	logic tx_err;
	logic stat_valid;
	logic [31:0] stat_word;

	modport dev (
		input wr_valid,
		input wr_data,
		input err_clear,
		output tx_err,
		output stat_valid,
		output stat_word
	);

	modport host (
		output wr_valid,
		output wr_data,
		output err_clear,
		input tx_err,
		input stat_valid,
		input stat_word
	);
endinterface : tbu_if
`default_nettype wire

// >>> rtl/tbu_dev.sv
// Device end: unpacks TX command words and strips offset and padding DWORDs
`default_nettype none
// Notes on behaviour
// - Command A bit 13 opens a packet
// - Command A bit 12 closes the packet
// - Command A bits 10:0 are payload bytes
// - Size plus alignment gives trailing DWORDs, dropped
// - Summed sizes differing from length raise error
// - Command B tag goes into status word
// - Command B bit 13 suppresses CRC append
// - Bit 12 stops padding, CRC then forced on
// - Command B bits 10:0 are packet length
// - Host writes zero to reserved bits
// - Payload starts at third DWORD of buffer
// - Offset low bits pick first byte lane
// - Offset bits 4:2 skip whole leading DWORDs
// - Bytes past payload are not forwarded
// - Tail padding to alignment removed by device
// - Any start, end, first and last length
// - Host keeps middle buffers at four bytes or more
// - Host caps store-forward footprint at 2036 bytes
// - Host treats over 86 buffers as fragmented in store-forward mode only
// - Differing command B in packet raises error
module tbu_dev (
	input wire logic core_clk,
	input wire logic rst_n,
	tbu_if.dev lk,
	output logic out_valid,
	output logic [31:0] out_data,
	output logic [3:0] out_be,
	output logic out_last,
	output logic [15:0] pkt_tag,
	output logic pkt_crc_add,
	output logic pkt_pad_add
);
	import tbu_pkg::*;

	typedef struct packed {
		tbu_dev_state_t state;
		// Command words of the buffer in flight
		logic [31:0] cmd_a;
		logic [31:0] cmd_b;
		// Packet bookkeeping
		logic in_pkt;
		logic pkt_err;
		logic [11:0] acc;
		logic [11:0] cnt;
		logic [11:0] total;
		logic [11:0] dend;
		logic err_flag;
		// Forwarded data
		logic out_valid;
		logic [31:0] out_data;
		logic [3:0] out_be;
		logic out_last;
		// Per-packet MAC controls
		logic [15:0] tag;
		logic crc_add;
		logic pad_add;
		// Status towards the host
		logic stat_valid;
		logic [31:0] stat_word;
	} tbu_dev_st_t;

	tbu_dev_st_t st_reg;
	tbu_dev_st_t st_next;

	always_comb
	begin
		logic set_err;
		logic fin;
		logic [10:0] size;
		logic [4:0] off;

		set_err = 1'b0;
		fin = 1'b0;
		size = 11'h000;
		off = 5'h00;
		st_next = st_reg;
		// Pulses stand for one cycle only
		st_next.out_valid = 1'b0;
		st_next.out_last = 1'b0;
		st_next.stat_valid = 1'b0;

		// Clear first so that a set later in the cycle wins
		if (lk.err_clear)
			st_next.err_flag = 1'b0;

		if (lk.wr_valid)
		begin
			case (st_reg.state)
				DS_CMD_A:
				begin
					st_next.cmd_a = lk.wr_data;
					size = lk.wr_data[A_SIZE_MSB:0];
					st_next.state = DS_CMD_B;
					if (lk.wr_data[A_FIRST_BIT])
					begin
						// A missing closing segment raises the error, charged to the new packet
						set_err = st_reg.in_pkt;
						st_next.in_pkt = 1'b1;
						st_next.pkt_err = 1'b0;
						st_next.acc = {1'b0, size};
					end
					else
					begin
						// Continuation without an open packet is an error
						set_err = !st_reg.in_pkt;
						// Middle buffer length is left to the host
						st_next.acc = st_reg.acc + {1'b0, size};
					end
				end

				DS_CMD_B:
				begin
					// Payload follows right after this word
					st_next.cmd_b = lk.wr_data;
					size = st_reg.cmd_a[A_SIZE_MSB:0];
					off = st_reg.cmd_a[A_OFF_MSB:A_OFF_LSB];
					if (st_reg.cmd_a[A_FIRST_BIT])
					begin
						st_next.tag = lk.wr_data[B_TAG_MSB:B_TAG_LSB];
						// Padding off forces CRC on
						st_next.crc_add = !lk.wr_data[B_CRC_DIS_BIT] || lk.wr_data[B_PAD_DIS_BIT];
						st_next.pad_add = !lk.wr_data[B_PAD_DIS_BIT];
					end
					else if (lk.wr_data != st_reg.cmd_b)
						set_err = 1'b1;
					st_next.total = tbu_total_dw(off, size, st_reg.cmd_a[A_ALIGN_MSB:A_ALIGN_LSB]);
					st_next.dend = tbu_data_end_dw(off, size);
					st_next.cnt = 12'h000;
					st_next.state = DS_BODY;
					// Empty buffer with no offset has no body at all
					fin = (st_next.total == 12'h000);
				end

				DS_BODY:
				begin
					// Counter runs over offset, payload and padding DWORDs alike
					size = st_reg.cmd_a[A_SIZE_MSB:0];
					off = st_reg.cmd_a[A_OFF_MSB:A_OFF_LSB];
					// Whole offset DWORDs and trailing padding DWORDs are dropped
					if (st_reg.cnt >= {9'h000, off[4:2]} && st_reg.cnt < st_reg.dend)
					begin
						st_next.out_valid = 1'b1;
						st_next.out_data = lk.wr_data;
						st_next.out_be = tbu_byte_en(st_reg.cnt, off, size);
						st_next.out_last = st_reg.cmd_a[A_LAST_BIT] && (st_reg.cnt + 12'h001 == st_reg.dend);
					end
					st_next.cnt = st_reg.cnt + 12'h001;
					fin = (st_reg.cnt + 12'h001 == st_reg.total);
				end

				default:
					st_next.state = DS_CMD_A;
			endcase
		end

		// Buffer fully taken: next word is a command A
		if (fin)
		begin
			st_next.state = DS_CMD_A;
			if (st_next.cmd_a[A_LAST_BIT])
			begin
				// Closing buffer: check the running count and report
				if (st_next.acc != {1'b0, st_next.cmd_b[B_LEN_MSB:0]})
					set_err = 1'b1;
				st_next.in_pkt = 1'b0;
				st_next.stat_valid = 1'b1;
				st_next.stat_word = {st_next.tag, st_next.pkt_err | set_err, 15'h0000};
			end
		end

		// Set wins over a clear in the same cycle
		if (set_err)
		begin
			st_next.err_flag = 1'b1;
			st_next.pkt_err = 1'b1;
		end
	end

	// Synchronous reset returns to waiting for a command A
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			st_reg <= '0;
			st_reg.state <= DS_CMD_A;
		end
		else
			st_reg <= st_next;
	end

	// Data and lanes keep their value between pulses; only valid marks them
	assign lk.tx_err = st_reg.err_flag;
	assign lk.stat_valid = st_reg.stat_valid;
	assign lk.stat_word = st_reg.stat_word;
	assign out_valid = st_reg.out_valid;
	assign out_data = st_reg.out_data;
	assign out_be = st_reg.out_be;
	assign out_last = st_reg.out_last;
	assign pkt_tag = st_reg.tag;
	assign pkt_crc_add = st_reg.crc_add;
	assign pkt_pad_add = st_reg.pad_add;
endmodule : tbu_dev
`default_nettype wire

// >>> rtl/tbu_host.sv
// Host end: builds command words and writes buffer DWORDs to the device
`default_nettype none
module tbu_host (
	input wire logic core_clk,
	input wire logic rst_n,
	tbu_if.host lk,
	input wire logic store_forward_select,
	input wire logic u_buf_valid,
	output logic u_buf_ready,
	output logic u_reject,
	input wire logic u_first,
	input wire logic u_last,
	input wire logic [10:0] u_size,
	input wire logic [4:0] u_off,
	input wire logic [1:0] u_align,
	input wire logic [15:0] u_tag,
	input wire logic u_crc_dis,
	input wire logic u_pad_dis,
	input wire logic [10:0] u_pkt_len,
	input wire logic u_data_valid,
	output logic u_data_ready,
	input wire logic [31:0] u_data,
	input wire logic u_err_clear,
	output logic tx_error,
	output logic status_valid,
	output logic [31:0] status_word
);
	import tbu_pkg::*;

	typedef struct packed {
		tbu_host_state_t state;
		logic [31:0] cmd_b;
		logic [11:0] cnt;
		logic [11:0] total;
		logic [7:0] frags;
		logic [11:0] fp;
		logic wr_valid;
		logic [31:0] wr_data;
		logic reject;
		logic stat_valid;
		logic [31:0] stat_word;
	} tbu_host_st_t;

	tbu_host_st_t st_reg;
	tbu_host_st_t st_next;

	always_comb
	begin
		logic [11:0] dend;
		logic [11:0] bytes;
		logic [7:0] frags;
		logic [11:0] fp;
		dend = tbu_data_end_dw(u_off, u_size);
		// Footprint counts only DWORDs that reach the data FIFO
		bytes = (dend - {9'h000, u_off[4:2]}) << 2;
		frags = u_first ? 8'h01 : st_reg.frags + 8'h01;
		fp = u_first ? bytes : st_reg.fp + bytes;
		st_next = st_reg;
		st_next.wr_valid = 1'b0;
		st_next.reject = 1'b0;
		st_next.stat_valid = lk.stat_valid;
		if (lk.stat_valid)
			st_next.stat_word = lk.stat_word;
		case (st_reg.state)
			HS_IDLE:
			begin
				if (u_buf_valid)
				begin
					if ((!u_first && !u_last && {1'b0, u_size} < MIN_MID_BYTES)
						|| (store_forward_select && (frags > MAX_FRAGS || fp > SF_LIMIT_BYTES)))
						st_next.reject = 1'b1;
					else
					begin
						st_next.frags = frags;
						st_next.fp = fp;
						st_next.wr_valid = 1'b1;
						st_next.wr_data = {1'b0, 5'h00, u_align, 3'h0, u_off, 2'h0, u_first, u_last, 1'b0, u_size}
							& CMD_A_MASK;
						st_next.cmd_b = {u_tag, 2'h0, u_crc_dis, u_pad_dis, 1'b0, u_pkt_len} & CMD_B_MASK;
						st_next.total = tbu_total_dw(u_off, u_size, u_align);
						st_next.state = HS_CMD_B;
					end
				end
			end
			HS_CMD_B:
			begin
				// Command B word built from this buffer's inputs goes out next; nothing here makes it match the packet's first buffer
				st_next.wr_valid = 1'b1;
				st_next.wr_data = st_reg.cmd_b;
				st_next.cnt = 12'h000;
				st_next.state = (st_reg.total == 12'h000) ? HS_IDLE : HS_DATA;
			end
			HS_DATA:
			begin
				if (u_data_valid)
				begin
					st_next.wr_valid = 1'b1;
					st_next.wr_data = u_data;
					st_next.cnt = st_reg.cnt + 12'h001;
					if (st_reg.cnt + 12'h001 == st_reg.total)
						st_next.state = HS_IDLE;
				end
			end
			default:
				st_next.state = HS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			st_reg <= '0;
			st_reg.state <= HS_IDLE;
		end
		else
			st_reg <= st_next;
	end

	assign u_buf_ready = (st_reg.state == HS_IDLE);
	assign u_data_ready = (st_reg.state == HS_DATA);
	assign u_reject = st_reg.reject;
	assign lk.wr_valid = st_reg.wr_valid;
	assign lk.wr_data = st_reg.wr_data;
	assign lk.err_clear = u_err_clear;
	assign tx_error = lk.tx_err;
	assign status_valid = st_reg.stat_valid;
	assign status_word = st_reg.stat_word;
endmodule : tbu_host
`default_nettype wire

// >>> tb/tbu_link_chk.sv
// Protocol checker on the link between the host end and the device end
`default_nettype none
module tbu_link_chk
	import tbu_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wr_valid,
	input wire logic [31:0] wr_data,
	input wire logic err_clear,
	input wire logic tx_err,
	input wire logic stat_valid,
	input wire logic [31:0] stat_word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph_reg;
	logic [11:0] rem_reg;
	logic [31:0] ca_reg;
	logic [31:0] cb_reg;
	logic [11:0] s;
	logic [11:0] tot;
	logic end_buf;
	logic end_pkt;
	logic err_pt;
	// Only meaningful while the word on the link is a first command word
	assign s = 12'(wr_data[20:16]) + 12'(wr_data[10:0]);
	assign tot = (wr_data[25:24] == ALIGN_16) ? ((s + 12'h00f) >> 4) << 2 :
		(wr_data[25:24] == ALIGN_32) ? ((s + 12'h01f) >> 5) << 3 : (s + 12'h003) >> 2;
	assign end_buf = wr_valid && ((ph_reg == 2'h2 && rem_reg == 12'h001) || (ph_reg == 2'h1 && rem_reg == 12'h000));
	assign end_pkt = end_buf && ca_reg[A_LAST_BIT];
	// Command words and buffer ends are the only places the error flag may be set
	assign err_pt = (wr_valid && ph_reg != 2'h2) || end_buf;
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			ph_reg <= 2'h0;
		else if (wr_valid)
		begin
			case (ph_reg)
				2'h0:
				begin
					ca_reg <= wr_data;
					rem_reg <= tot;
					ph_reg <= 2'h1;
				end
				2'h1:
				begin
					cb_reg <= wr_data;
					ph_reg <= (rem_reg == 12'h000) ? 2'h0 : 2'h2;
				end
				default:
				begin
					rem_reg <= rem_reg - 12'h001;
					ph_reg <= (rem_reg == 12'h001) ? 2'h0 : 2'h2;
				end
			endcase
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chk_cmd_a_resv: assert property (wr_valid && ph_reg == 2'h0 |-> (wr_data & ~CMD_A_MASK) == 32'h0)
		else $error("reserved bit set in first command word");
	chk_cmd_b_resv: assert property (wr_valid && ph_reg == 2'h1 |-> (wr_data & ~CMD_B_MASK) == 32'h0)
		else $error("reserved bit set in second command word");
	chk_cmd_follow: assert property (wr_valid && ph_reg == 2'h0 |=> wr_valid)
		else $error("second command word did not follow the first");
	chk_stat_end: assert property (end_pkt |=> stat_valid)
		else $error("no status after closing buffer");
	chk_stat_cause: assert property (stat_valid |-> $past(end_pkt))
		else $error("status without a closing buffer");
	chk_stat_tag: assert property (stat_valid |-> stat_word[31:16] == cb_reg[31:16])
		else $error("status tag differs from command tag");
	chk_err_hold: assert property (tx_err && !err_clear |=> tx_err)
		else $error("error flag dropped without clear");
	chk_err_rise: assert property ($rose(tx_err) |-> $past(err_pt))
		else $error("error flag rose away from a command word or buffer end");
	chk_err_clear: assert property (err_clear && !err_pt |=> !tx_err)
		else $error("error flag survived a clear");
endmodule : tbu_link_chk
`default_nettype wire

// >>> tb/tb_tx_buffer_command_unpacker.sv
// Bench joining host and device ends, driving buffers and checking forwarded data
`default_nettype none
module tb_tx_buffer_command_unpacker;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, rst_n = 1'b0, store_forward_select = 1'b1, u_buf_valid = 1'b0, u_first = 1'b0;
	logic u_last = 1'b0, u_crc_dis = 1'b0, u_pad_dis = 1'b0, u_data_valid = 1'b0, u_err_clear = 1'b0;
	logic [10:0] u_size = 11'h000, u_pkt_len = 11'h000;
	logic [4:0] u_off = 5'h00;
	logic [1:0] u_align = 2'h0;
	logic [15:0] u_tag = 16'h0000, pkt_tag, ptag;
	logic [31:0] u_data = 32'h0, status_word, out_data, st;
	logic u_buf_ready, u_reject, u_data_ready, tx_error, status_valid, out_valid, out_last, pkt_crc_add, pkt_pad_add;
	logic [3:0] out_be;
	logic [36:0] q[$];
	logic sv;
	int failures = 0, checked = 0;
	// Fields: first, last, size, offset, align, crc off, pad off, length, error, refused
	int rows [11][10] = '{'{1, 1, 5, 2, 0, 0, 0, 5, 0, 0}, '{1, 1, 1, 31, 2, 1, 0, 1, 0, 0},
		'{1, 0, 79, 7, 1, 0, 1, 111, 0, 0}, '{0, 0, 3, 0, 1, 0, 1, 111, 0, 1}, '{0, 0, 15, 0, 1, 0, 1, 111, 0, 0},
		'{0, 1, 17, 10, 1, 0, 1, 111, 0, 0}, '{1, 1, 0, 0, 3, 1, 1, 0, 0, 0}, '{1, 1, 4, 3, 0, 0, 0, 5, 1, 0},
		'{1, 0, 4, 0, 0, 0, 0, 8, 0, 0}, '{0, 1, 5, 1, 0, 0, 0, 9, 1, 0},
		'{1, 1, 2047, 0, 0, 0, 0, 2047, 0, 1}};
	tbu_if lk ();
	tbu_dev u_tbu_dev (.core_clk, .rst_n, .lk, .out_valid, .out_data, .out_be, .out_last, .pkt_tag, .pkt_crc_add,
		.pkt_pad_add);
	tbu_host u_tbu_host (.core_clk, .rst_n, .lk, .store_forward_select, .u_buf_valid, .u_buf_ready, .u_reject,
		.u_first, .u_last, .u_size, .u_off, .u_align, .u_tag, .u_crc_dis, .u_pad_dis, .u_pkt_len, .u_data_valid,
		.u_data_ready, .u_data, .u_err_clear, .tx_error, .status_valid, .status_word);
	tbu_link_chk u_tbu_link_chk (.core_clk, .rst_n, .wr_valid(lk.wr_valid), .wr_data(lk.wr_data),
		.err_clear(lk.err_clear), .tx_err(lk.tx_err), .stat_valid(lk.stat_valid), .stat_word(lk.stat_word));
	initial
	begin
		forever #50 core_clk = ~core_clk;
	end
	// Sampled mid-cycle so registered outputs have settled
	always @(negedge core_clk)
	begin
		if (out_valid === 1'b1)
			q.push_back({out_last, out_be, out_data});
		if (status_valid === 1'b1)
		begin
			sv = 1'b1;
			st = status_word;
		end
	end
	function automatic int tot(input int off, input int sz, input int al);
		int s;
		s = off + sz;
		if (al == 1)
			return (s + 15) / 16 * 4;
		if (al == 2)
			return (s + 31) / 32 * 8;
		return (s + 3) / 4;
	endfunction : tot
	function automatic logic [31:0] pat(input int i);
		return {8'(i), 8'h3c, 8'(~i), 8'(i + 7)};
	endfunction : pat
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up;
		if (failures == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	task automatic run(input int r);
		int w[10];
		int n;
		int i;
		int cnt;
		int idx;
		logic [3:0] be;
		w = rows[r];
		n = w[9] ? 0 : tot(w[3], w[2], w[4]);
		if (w[0] == 1)
			ptag = 16'h5a00 + 16'(r);
		do @(negedge core_clk); while (u_buf_ready !== 1'b1);
		@(posedge core_clk);
		u_err_clear <= (w[0] == 1 && w[9] == 0);
		u_first <= 1'(w[0]);
		u_last <= 1'(w[1]);
		u_size <= 11'(w[2]);
		u_off <= 5'(w[3]);
		u_align <= 2'(w[4]);
		u_crc_dis <= 1'(w[5]);
		u_pad_dis <= 1'(w[6]);
		u_pkt_len <= 11'(w[7]);
		u_tag <= ptag;
		u_buf_valid <= 1'b1;
		u_data_valid <= (n > 0);
		u_data <= pat(0);
		@(posedge core_clk);
		u_buf_valid <= 1'b0;
		u_err_clear <= 1'b0;
		q.delete();
		sv = 1'b0;
		@(negedge core_clk);
		chk(32'(u_reject), 32'(w[9]));
		i = 0;
		while (i < n)
		begin
			if (u_data_ready === 1'b1)
			begin
				@(posedge core_clk);
				i++;
				u_data <= pat(i);
				u_data_valid <= (i < n);
			end
			@(negedge core_clk);
		end
		repeat (4) @(negedge core_clk);
		cnt = w[9] ? 0 : (w[3] + w[2] + 3) / 4 - w[3] / 4;
		chk(32'(q.size()), 32'(cnt));
		foreach (q[j])
		begin
			idx = w[3] / 4 + j;
			for (int k = 0; k < 4; k++)
				be[k] = (4 * idx + k >= w[3]) && (4 * idx + k < w[3] + w[2]);
			chk({27'h0, q[j][36:32]}, {27'h0, j == cnt - 1 && w[1] == 1, be});
			chk(q[j][31:0], pat(idx));
		end
		chk(32'(sv), 32'(w[1] == 1 && w[9] == 0));
		if (w[1] == 1 && w[9] == 0)
		begin
			chk(st, {ptag, w[8] == 1, 15'h0});
			chk(32'(tx_error), 32'(w[8]));
		end
		if (w[0] == 1 && w[9] == 0)
			chk({14'h0, pkt_crc_add, pkt_pad_add, pkt_tag}, {14'h0, w[5] == 0 || w[6] == 1, w[6] == 0, ptag});
	endtask : run
	initial
	begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		foreach (rows[r])
			run(r);
		// Flag is still set from the last packet, so reset must clear it
		chk(32'(tx_error), 32'h1);
		@(posedge core_clk);
		rst_n <= 1'b0;
		@(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		chk({30'h0, tx_error, status_valid}, 32'h0);
		run(0);
		wrap_up;
	end
	initial
	begin
		#500000;
		failures++;
		wrap_up;
	end
endmodule : tb_tx_buffer_command_unpacker
`default_nettype wire
